// File: shared/ctp_consts.vh
// constants for the channel time and periodic schedule walker block
// assumes inclusion by bare name from the design file, no other dependency
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH

// timing
`define CTP_CLK_PERIOD_PS 5000
`define CTP_TICK_US_PS 1000000
`define CTP_US_LAST 7'h7C
`define CTP_EIGHTH_MS_LAST 17'h1FFFF
`define CTP_SLOT_US 256

// register offsets (byte addresses)
`define CTP_OFS_CMD 8'h00
`define CTP_OFS_STS 8'h04
`define CTP_OFS_INTR 8'h08
`define CTP_OFS_BEACON_PERIOD_START_TIME 8'h0C
`define CTP_OFS_BEACON_PERIOD_START_ADJ 8'h10
`define CTP_OFS_ZONE_BASE 8'h14
`define CTP_OFS_SLOT_IDX 8'h18
`define CTP_OFS_CHAN_TIME 8'h1C
`define CTP_OFS_ASYNC_PTR 8'h20

// host_command_register bits
`define CTP_CMD_RUN 0
`define CTP_CMD_PER_EN 1
`define CTP_CMD_PER_UPD 2
`define CTP_CMD_CTL_RST 3

// host_status_register bits
`define CTP_STS_PER_STAT 0
`define CTP_STS_ADJ_CHG 1

// host_interrupt_enable_register bits
`define CTP_INTR_ADJ_EN 0
`define CTP_INTR_ROLLOVER 2

// schedule structures in memory
`define CTP_LINK_T 0
`define CTP_LINK_ADDR_LSB 4
`define CTP_QH_INFO_OFS 32'h00000004
`define CTP_QH_MAX_MSB 7
`define CTP_QH_ISO 8
`define CTP_QH_ACTIVE 9
`define CTP_ZONE_SHIFT 4
`define CTP_ELEM_SHIFT 2

`endif

// File: rtl/ctp_sched.v
// channel time counter, beacon start tracking and periodic schedule walker
// assumes a register master on the same clock, a memory read port that
// answers with an ack, and a transaction engine that reports each result
//
// How it works
// - 24-bit time: 17-bit eighth-ms, 7-bit us
// - channel time clears on either reset
// - time advances each microsecond once run set
// - microsecond count runs 0 to 124
// - eighth-ms count steps on us wrap
// - full time wrap sets rollover flag
// - time feeds timestamps and isochronous deadlines
// - beacon period end loads next start time
// - adjustment is final minus original start
// - changed adjustment sets status, gated interrupt
// - periodic work always ahead of asynchronous
// - active queue sets served each 16-slot zone
// - element address is base plus zone index times four
// - slot index clears per superframe, steps 256us
// - terminate bit rescans zone if the pass ran a transaction, else asynchronous
// - zone list untouched while periodic enable low
// - periodic status shows traversal really running
// - max count limits endpoint, iso may exceed
// - failed first try allows max minus one retries
// - interrupt endpoint done after one success
// - updated bit cleared once schedule resynchronised
`timescale 1ns/1ps
`include "ctp_consts.vh"

module ctp_sched #(
  parameter ADDR_W = 32,
  parameter DONE_DEPTH = 8
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire WHOLE_RADIO_RESET_I,
  input wire [7:0] REG_ADDR_I,
  input wire [31:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  output reg [31:0] REG_RDATA_O,
  input wire BP_END_I,
  input wire [23:0] BEACON_PERIOD_START_ORIG_I,
  input wire [23:0] BEACON_PERIOD_START_FINAL_I,
  input wire SUPERFRAME_START_I,
  output reg [23:0] CHAN_TIME_O,
  output wire IRQ_O,
  output reg MEM_RD_REQ_O,
  output reg [ADDR_W-1:0] MEM_ADDR_O,
  input wire MEM_RD_ACK_I,
  input wire [31:0] MEM_RDATA_I,
  output wire TXN_REQ_O,
  output reg [ADDR_W-1:0] TXN_QS_ADDR_O,
  output reg TXN_ISO_O,
  input wire TXN_DONE_I,
  input wire TXN_OK_I,
  input wire TXN_SPARE_I,
  output wire ASYNC_GO_O
);

  localparam integer TICK_CYCLES = `CTP_TICK_US_PS / `CTP_CLK_PERIOD_PS;
  localparam integer TICK_LAST_INT = TICK_CYCLES - 1;
  localparam integer SLOT_LAST_INT = `CTP_SLOT_US - 1;
  localparam [7:0] TICK_LAST = TICK_LAST_INT[7:0];
  localparam [7:0] SLOT_US_LAST = SLOT_LAST_INT[7:0];

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ZRD = 7'h02;
  localparam [6:0] S_LRD = 7'h04;
  localparam [6:0] S_HRD = 7'h08;
  localparam [6:0] S_TXN = 7'h10;
  localparam [6:0] S_NEXT = 7'h20;
  localparam [6:0] S_DONE = 7'h40;

  function is_wr;
    input [7:0] ofs;
    begin
      is_wr = REG_WR_I && (REG_ADDR_I == ofs);
    end
  endfunction

  function [ADDR_W-1:0] link_addr;
    input [31:0] word;
    begin
      link_addr = {word[ADDR_W-1:`CTP_LINK_ADDR_LSB], {`CTP_LINK_ADDR_LSB{1'b0}}};
    end
  endfunction

  // either reset source, plus the self-clearing controller reset bit
  wire ctl_rst_bit = is_wr(`CTP_OFS_CMD) && REG_WDATA_I[`CTP_CMD_CTL_RST];
  wire rst = SRST_I || WHOLE_RADIO_RESET_I || ctl_rst_bit;

  reg run_reg;
  reg per_en_reg;
  reg per_upd_reg;
  reg per_stat_reg;
  reg adj_chg_reg;
  reg adj_en_reg;
  reg rollover_reg;
  reg [23:0] beacon_period_start_time_reg;
  reg [15:0] beacon_period_start_adj_reg;
  reg [ADDR_W-1:0] zone_base_reg;
  reg [ADDR_W-1:0] async_ptr_reg;
  reg [7:0] slot_idx_reg;

  reg [7:0] tick_cnt_reg;
  reg [6:0] us_cnt_reg;
  reg [16:0] ems_cnt_reg;
  reg [7:0] slot_us_reg;

  reg [6:0] state_reg;
  reg [ADDR_W-1:0] qs_reg;
  reg [31:0] link_reg;
  reg [`CTP_QH_MAX_MSB:0] max_reg;
  reg [`CTP_QH_MAX_MSB:0] cnt_reg;
  reg pass_txn_reg;
  reg slot_done_reg;
  reg [3:0] zone_seen_reg;
  reg [ADDR_W-1:0] done_addr [0:DONE_DEPTH-1];
  reg [DONE_DEPTH-1:0] done_vld_reg;
  reg [2:0] done_ptr_reg;

  wire us_tick = run_reg && (tick_cnt_reg == TICK_LAST);
  wire us_wrap = us_tick && (us_cnt_reg == `CTP_US_LAST);
  wire time_wrap = us_wrap && (ems_cnt_reg == `CTP_EIGHTH_MS_LAST);
  wire [3:0] zone_idx = slot_idx_reg[7:`CTP_ZONE_SHIFT];
  wire [15:0] adj_new = BEACON_PERIOD_START_FINAL_I[15:0] - BEACON_PERIOD_START_ORIG_I[15:0];
  wire sync_now = (state_reg == S_IDLE) && per_upd_reg;

  // previously served queue set within the current zone
  reg done_hit;
  integer k;
  always @* begin
    done_hit = 1'b0;
    for (k = 0; k < DONE_DEPTH; k = k + 1) begin
      if (done_vld_reg[k] && (done_addr[k] == qs_reg)) begin
        done_hit = 1'b1;
      end
    end
  end

  // channel time counter
  always @(posedge CLK_I) begin
    if (rst) begin
      tick_cnt_reg <= 8'h00;
      us_cnt_reg <= 7'h00;
      ems_cnt_reg <= 17'h00000;
      CHAN_TIME_O <= 24'h000000;
    end else begin
      if (!run_reg) begin
        tick_cnt_reg <= 8'h00;
      end else if (us_tick) begin
        tick_cnt_reg <= 8'h00;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 8'h01;
      end
      if (us_wrap) begin
        us_cnt_reg <= 7'h00;
        ems_cnt_reg <= ems_cnt_reg + 17'h00001;
      end else if (us_tick) begin
        us_cnt_reg <= us_cnt_reg + 7'h01;
      end
      CHAN_TIME_O <= {ems_cnt_reg, us_cnt_reg};
    end
  end

  // slot index: cleared at superframe start, steps every slot length
  always @(posedge CLK_I) begin
    if (rst) begin
      slot_idx_reg <= 8'h00;
      slot_us_reg <= 8'h00;
    end else if (SUPERFRAME_START_I) begin
      slot_idx_reg <= 8'h00;
      slot_us_reg <= 8'h00;
    end else if (us_tick) begin
      slot_us_reg <= slot_us_reg + 8'h01;
      if (slot_us_reg == SLOT_US_LAST) begin
        slot_idx_reg <= slot_idx_reg + 8'h01;
      end
    end
  end

  // control and status registers
  always @(posedge CLK_I) begin
    if (rst) begin
      run_reg <= 1'b0;
      per_en_reg <= 1'b0;
      per_upd_reg <= 1'b0;
      adj_chg_reg <= 1'b0;
      adj_en_reg <= 1'b0;
      rollover_reg <= 1'b0;
      beacon_period_start_time_reg <= 24'h000000;
      beacon_period_start_adj_reg <= 16'h0000;
      zone_base_reg <= {ADDR_W{1'b0}};
      async_ptr_reg <= {ADDR_W{1'b0}};
    end else begin
      if (is_wr(`CTP_OFS_CMD)) begin
        run_reg <= REG_WDATA_I[`CTP_CMD_RUN];
        per_en_reg <= REG_WDATA_I[`CTP_CMD_PER_EN];
      end
      // software set wins over the hardware clear after resync
      if (is_wr(`CTP_OFS_CMD) && REG_WDATA_I[`CTP_CMD_PER_UPD]) begin
        per_upd_reg <= 1'b1;
      end else if (sync_now) begin
        per_upd_reg <= 1'b0;
      end
      if (is_wr(`CTP_OFS_INTR)) begin
        adj_en_reg <= REG_WDATA_I[`CTP_INTR_ADJ_EN];
      end
      if (time_wrap) begin
        rollover_reg <= 1'b1;
      end else if (is_wr(`CTP_OFS_INTR) && REG_WDATA_I[`CTP_INTR_ROLLOVER]) begin
        rollover_reg <= 1'b0;
      end
      if (BP_END_I) begin
        beacon_period_start_time_reg <= BEACON_PERIOD_START_FINAL_I;
        beacon_period_start_adj_reg <= adj_new;
      end
      if (BP_END_I && (adj_new != beacon_period_start_adj_reg)) begin
        adj_chg_reg <= 1'b1;
      end else if (is_wr(`CTP_OFS_STS) && REG_WDATA_I[`CTP_STS_ADJ_CHG]) begin
        adj_chg_reg <= 1'b0;
      end
      if (is_wr(`CTP_OFS_ZONE_BASE)) begin
        zone_base_reg <= REG_WDATA_I[ADDR_W-1:0];
      end
      if (is_wr(`CTP_OFS_ASYNC_PTR)) begin
        async_ptr_reg <= REG_WDATA_I[ADDR_W-1:0];
      end
    end
  end

  assign IRQ_O = adj_chg_reg && adj_en_reg;

  // register read port, data one cycle after the strobe
  always @(posedge CLK_I) begin
    if (rst) begin
      REG_RDATA_O <= 32'h00000000;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        `CTP_OFS_CMD: REG_RDATA_O <= {29'h0, per_upd_reg, per_en_reg, run_reg};
        `CTP_OFS_STS: REG_RDATA_O <= {30'h0, adj_chg_reg, per_stat_reg};
        `CTP_OFS_INTR: REG_RDATA_O <= {29'h0, rollover_reg, 1'b0, adj_en_reg};
        `CTP_OFS_BEACON_PERIOD_START_TIME: REG_RDATA_O <= {8'h00, beacon_period_start_time_reg};
        `CTP_OFS_BEACON_PERIOD_START_ADJ: REG_RDATA_O <= {16'h0000, beacon_period_start_adj_reg};
        `CTP_OFS_ZONE_BASE: REG_RDATA_O <= zone_base_reg;
        `CTP_OFS_SLOT_IDX: REG_RDATA_O <= {24'h000000, slot_idx_reg};
        `CTP_OFS_CHAN_TIME: REG_RDATA_O <= {8'h00, ems_cnt_reg, us_cnt_reg};
        `CTP_OFS_ASYNC_PTR: REG_RDATA_O <= async_ptr_reg;
        default: REG_RDATA_O <= 32'h00000000;
      endcase
    end else begin
      REG_RDATA_O <= 32'h00000000;
    end
  end

  // periodic walker
  wire mem_ok = MEM_RD_REQ_O && MEM_RD_ACK_I;
  wire [ADDR_W-1:0] elem_addr = zone_base_reg +
    {{(ADDR_W-6){1'b0}}, zone_idx, 2'b00};
  wire [`CTP_QH_MAX_MSB:0] cnt_inc = cnt_reg + 1'b1;
  wire lim_hit = (cnt_inc >= max_reg) && !(TXN_ISO_O && TXN_SPARE_I);
  wire txn_stop = (TXN_OK_I && !TXN_ISO_O) || lim_hit;

  always @(posedge CLK_I) begin
    if (rst) begin
      state_reg <= S_IDLE;
      per_stat_reg <= 1'b0;
      MEM_RD_REQ_O <= 1'b0;
      MEM_ADDR_O <= {ADDR_W{1'b0}};
      TXN_QS_ADDR_O <= {ADDR_W{1'b0}};
      TXN_ISO_O <= 1'b0;
      qs_reg <= {ADDR_W{1'b0}};
      link_reg <= 32'h00000000;
      max_reg <= 8'h00;
      cnt_reg <= 8'h00;
      pass_txn_reg <= 1'b0;
      slot_done_reg <= 1'b0;
      zone_seen_reg <= 4'h0;
      done_vld_reg <= {DONE_DEPTH{1'b0}};
      done_ptr_reg <= 3'h0;
    end else begin
      if (zone_seen_reg != zone_idx) begin
        zone_seen_reg <= zone_idx;
        done_vld_reg <= {DONE_DEPTH{1'b0}};
      end
      if (SUPERFRAME_START_I || (us_tick && slot_us_reg == SLOT_US_LAST)) begin
        slot_done_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          per_stat_reg <= per_en_reg && run_reg;
          if (sync_now) begin
            done_vld_reg <= {DONE_DEPTH{1'b0}};
          end else if (per_en_reg && run_reg && !slot_done_reg) begin
            MEM_RD_REQ_O <= 1'b1;
            MEM_ADDR_O <= elem_addr;
            pass_txn_reg <= 1'b0;
            state_reg <= S_ZRD;
          end
        end
        S_ZRD, S_NEXT: begin
          if (state_reg == S_ZRD && mem_ok) begin
            MEM_RD_REQ_O <= 1'b0;
            link_reg <= MEM_RDATA_I;
            state_reg <= S_NEXT;
          end else if (state_reg == S_NEXT) begin
            if (link_reg[`CTP_LINK_T]) begin
              // no rescan of the zone list once periodic enable is dropped
              if (pass_txn_reg && per_en_reg) begin
                MEM_RD_REQ_O <= 1'b1;
                MEM_ADDR_O <= elem_addr;
                pass_txn_reg <= 1'b0;
                state_reg <= S_ZRD;
              end else begin
                state_reg <= S_DONE;
              end
            end else begin
              qs_reg <= link_addr(link_reg);
              MEM_RD_REQ_O <= 1'b1;
              MEM_ADDR_O <= link_addr(link_reg);
              state_reg <= S_LRD;
            end
          end
        end
        S_LRD: begin
          if (mem_ok) begin
            link_reg <= MEM_RDATA_I;
            MEM_ADDR_O <= qs_reg + `CTP_QH_INFO_OFS;
            state_reg <= S_HRD;
          end
        end
        S_HRD: begin
          if (mem_ok) begin
            MEM_RD_REQ_O <= 1'b0;
            max_reg <= MEM_RDATA_I[`CTP_QH_MAX_MSB:0];
            TXN_ISO_O <= MEM_RDATA_I[`CTP_QH_ISO];
            TXN_QS_ADDR_O <= qs_reg;
            cnt_reg <= 8'h00;
            if (MEM_RDATA_I[`CTP_QH_ACTIVE] && !done_hit) begin
              state_reg <= S_TXN;
            end else begin
              state_reg <= S_NEXT;
            end
          end
        end
        S_TXN: begin
          if (TXN_DONE_I) begin
            cnt_reg <= cnt_inc;
            pass_txn_reg <= 1'b1;
            if (txn_stop) begin
              done_vld_reg[done_ptr_reg] <= 1'b1;
              done_ptr_reg <= done_ptr_reg + 3'h1;
              state_reg <= S_NEXT;
            end
          end
        end
        S_DONE: begin
          slot_done_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          MEM_RD_REQ_O <= 1'b0;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  always @(posedge CLK_I) begin
    if (state_reg == S_TXN && TXN_DONE_I && txn_stop) begin
      done_addr[done_ptr_reg] <= qs_reg;
    end
  end

  assign TXN_REQ_O = (state_reg == S_TXN);
  // asynchronous work only once the periodic walk has nothing left
  assign ASYNC_GO_O = run_reg && (state_reg == S_IDLE) &&
    (!per_stat_reg || slot_done_reg);

endmodule // ctp_sched

// File: sim/ctp_chk.sv
// checker: port timing of the channel time and schedule walker block
// assumes a bind onto ctp_sched, one clock CLK_I
`timescale 1ns/1ps
module ctp_chk #(
  parameter ADDR_W = 32
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire WHOLE_RADIO_RESET_I,
  input wire REG_RD_I,
  input wire [31:0] REG_RDATA_O,
  input wire [23:0] CHAN_TIME_O,
  input wire MEM_RD_REQ_O,
  input wire [ADDR_W-1:0] MEM_ADDR_O,
  input wire MEM_RD_ACK_I,
  input wire TXN_REQ_O,
  input wire TXN_ISO_O,
  input wire TXN_DONE_I,
  input wire TXN_OK_I,
  input wire ASYNC_GO_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I || WHOLE_RADIO_RESET_I);
  sequence s_tick;
    $changed(CHAN_TIME_O);
  endsequence
  sequence s_calm;
    $stable(CHAN_TIME_O) [*8];
  endsequence
  a_rdata_quiet: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
    else $error("read data not zero outside read");
  a_reset_zero: assert property ($fell(SRST_I || WHOLE_RADIO_RESET_I) |-> CHAN_TIME_O == 24'h0)
    else $error("time not zero after reset");
  a_us_range: assert property (CHAN_TIME_O[6:0] <= 7'h7C)
    else $error("microsecond count above limit");
  a_us_step: assert property (($changed(CHAN_TIME_O) && CHAN_TIME_O[6:0] != 7'h0) |->
    CHAN_TIME_O[6:0] == $past(CHAN_TIME_O[6:0]) + 7'h1)
    else $error("microsecond count skipped");
  a_ms_step: assert property (($changed(CHAN_TIME_O[23:7]) && CHAN_TIME_O != 24'h0) |->
    $past(CHAN_TIME_O[6:0]) == 7'h7C && CHAN_TIME_O[6:0] == 7'h0
    && CHAN_TIME_O[23:7] == $past(CHAN_TIME_O[23:7]) + 17'h1)
    else $error("eighth ms step wrong");
  a_tick_gap: assert property (s_tick |=> s_calm)
    else $error("time steps too fast");
  a_mem_hold: assert property (MEM_RD_REQ_O && !MEM_RD_ACK_I |=>
    MEM_RD_REQ_O && $stable(MEM_ADDR_O))
    else $error("memory request dropped");
  a_async_excl: assert property (ASYNC_GO_O |-> !TXN_REQ_O)
    else $error("async beside periodic work");
  a_txn_stop: assert property (TXN_REQ_O && TXN_DONE_I && TXN_OK_I && !TXN_ISO_O
    |=> !TXN_REQ_O)
    else $error("interrupt endpoint served again");
endmodule // ctp_chk

// File: sim/ctp_mem_model.sv
// partner: system memory holding the periodic schedule
// assumes one read held until ack, latency from lat_i
`timescale 1ns/1ps
module ctp_mem_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] lat_i,
  output logic ack_o,
  output logic [31:0] data_o
);
  logic [31:0] mem [0:1023];
  logic [31:0] adr_q [$];
  int wait_n;
  initial begin
    ack_o = 1'b0;
    data_o = 32'h0;
    wait_n = 0;
  end
  // data toggle between answers so a stale word never passes
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    data_o <= ~data_o;
    if (req_i && !ack_o) begin
      if (wait_n >= lat_i) begin
        ack_o <= 1'b1;
        data_o <= mem[addr_i[11:2]];
        adr_q.push_back(addr_i);
        wait_n = 0;
      end else
        wait_n++;
    end
  end
endmodule // ctp_mem_model

// File: sim/tb_top.sv
// testbench: registers, channel time, beacon start and periodic walk
// assumes ctp_sched, ctp_mem_model and ctp_chk compiled before it
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, rrst = 0, wr = 0, rd = 0, bpe = 0, sfs = 0, dn = 0, ok = 0, sp = 0;
  logic [7:0] ra = 0;
  logic [31:0] wd = 0, rv;
  logic [23:0] bo = 0, bf = 0;
  logic [3:0] lat = 0;
  wire [31:0] rdo, ma, md, qa;
  wire [23:0] ct;
  wire irq, mrq, mak, trq, iso, ago;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  logic [31:0] qsa [3] = '{32'h200, 32'h300, 32'h380};
  int mx [3] = '{3, 2, 2};
  int nn [3] = '{3, 2, 3};
  logic [1:0] oc [3][3] = '{'{2'h0, 2'h0, 2'h0}, '{2'h0, 2'h2, 2'h0}, '{2'h2, 2'h3, 2'h2}};
  ctp_sched dut_u (.CLK_I(clk), .SRST_I(rst), .WHOLE_RADIO_RESET_I(rrst), .REG_ADDR_I(ra),
    .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdo), .BP_END_I(bpe),
    .BEACON_PERIOD_START_ORIG_I(bo), .BEACON_PERIOD_START_FINAL_I(bf), .SUPERFRAME_START_I(sfs), .CHAN_TIME_O(ct),
    .IRQ_O(irq), .MEM_RD_REQ_O(mrq), .MEM_ADDR_O(ma), .MEM_RD_ACK_I(mak), .MEM_RDATA_I(md),
    .TXN_REQ_O(trq), .TXN_QS_ADDR_O(qa), .TXN_ISO_O(iso), .TXN_DONE_I(dn), .TXN_OK_I(ok),
    .TXN_SPARE_I(sp), .ASYNC_GO_O(ago));
  ctp_mem_model mem_u (.clk_i(clk), .req_i(mrq), .addr_i(ma), .lat_i(lat), .ack_o(mak),
    .data_o(md));
  initial forever #2.5 clk = ~clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_r(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); ra <= a; wd <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rd_r(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk); ra <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdo;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd_r(a, rv);
    chk(rv, e);
  endtask
  task txn(input logic o, input logic s, input logic e);
    @(posedge clk); dn <= 1'b1; ok <= o; sp <= s;
    @(posedge clk); dn <= 1'b0;
    @(negedge clk); chk(trq, e);
  endtask
  task end_sim;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin : main
    int t0;
    logic [23:0] adj, pa, b;
    logic [31:0] v;
    logic e;
    void'($urandom(32'hE3A9));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) if (i != 5) rc(8'(i * 4), 32'h0);
    v = $urandom;
    wr_r(8'h20, v);
    rc(8'h20, v);
    wr_r(8'h24, v);
    rc(8'h24, 32'h0);
    $display("register test done");
    wr_r(8'h00, 32'h1);
    rd_r(8'h1C, v);
    t0 = int'(v[23:7]) * 125 + int'(v[6:0]);
    repeat (25998) @(posedge clk);
    rd_r(8'h1C, v);
    chk(int'(v[23:7]) * 125 + int'(v[6:0]), t0 + 130);
    wr_r(8'h00, 32'h0);
    rd_r(8'h1C, v);
    repeat (400) @(posedge clk);
    rc(8'h1C, v);
    chk(ct, v);
    wr_r(8'h00, 32'h8);
    rc(8'h1C, 32'h0);
    $display("time test done");
    wr_r(8'h00, 32'h1);
    pa = 24'h0;
    for (int i = 0; i < 4; i++) begin
      adj = (i == 2) ? pa : 24'($urandom_range(1, 65535));
      wr_r(8'h04, 32'h2);
      wr_r(8'h08, 32'(i % 2));
      // first period repeats the previous adjustment, second applies the new one
      b = 24'($urandom);
      @(posedge clk); bo <= b; bpe <= 1'b1;
      bf <= b + pa;
      @(posedge clk); bpe <= 1'b0;
      bf <= b + adj;
      @(posedge clk); bpe <= 1'b1;
      @(posedge clk); bpe <= 1'b0;
      repeat (2) @(posedge clk);
      rc(8'h0C, {8'h0, bo + adj});
      rc(8'h10, {16'h0, adj[15:0]});
      rc(8'h04, {30'h0, adj != pa, 1'b0});
      chk(irq, (adj != pa) && (i % 2 == 1));
      pa = adj;
    end
    @(posedge clk); rrst <= 1'b1;
    @(posedge clk); rrst <= 1'b0;
    rc(8'h0C, 32'h0);
    $display("beacon test done");
    mem_u.mem[10'h40] = 32'h200;
    mem_u.mem[10'h80] = 32'h300;
    mem_u.mem[10'h81] = 32'h203;
    mem_u.mem[10'hC0] = 32'h380;
    mem_u.mem[10'hC1] = 32'h202;
    mem_u.mem[10'hE0] = 32'h1;
    mem_u.mem[10'hE1] = 32'h302;
    @(posedge clk); lat <= 4'($urandom_range(0, 3)); sfs <= 1'b1;
    @(posedge clk); sfs <= 1'b0;
    rc(8'h18, 32'h0);
    wr_r(8'h14, 32'h100);
    wr_r(8'h00, 32'h1);
    repeat (100) @(posedge clk);
    chk(mem_u.adr_q.size(), 0);
    wr_r(8'h00, 32'h3);
    v = 32'h0;
    for (int i = 0; i < 50 && v[0] !== 1'b1; i++) rd_r(8'h04, v);
    chk(v[0], 1'b1);
    for (int q = 0; q < 3; q++) begin
      for (int i = 0; i < 500 && trq !== 1'b1; i++) @(negedge clk);
      chk(qa, qsa[q]);
      chk(iso, q == 2);
      chk(ago, 1'b0);
      for (int k = 0; k < nn[q]; k++) begin
        e = (q == 2) ? (k + 1 < mx[q] || oc[q][k][0]) : (!oc[q][k][1] && k + 1 < mx[q]);
        txn(oc[q][k][1], oc[q][k][0], e);
      end
    end
    for (int i = 0; i < 500 && ago !== 1'b1; i++) @(negedge clk);
    chk(ago, 1'b1);
    chk(mem_u.adr_q[0], 32'h100);
    chk(mem_u.adr_q[2], 32'h204);
    chk(mem_u.adr_q[7], 32'h100);
    wr_r(8'h00, 32'h7);
    v = 32'h4;
    for (int i = 0; i < 50 && v[2] !== 1'b0; i++) rd_r(8'h00, v);
    chk(v[2], 1'b0);
    wr_r(8'h00, 32'h1);
    for (int i = 0; i < 50 && v[0] !== 1'b0; i++) rd_r(8'h04, v);
    chk(v[0], 1'b0);
    $display("walk test done");
    end_sim;
  end
endmodule // tb_top
bind ctp_sched ctp_chk #(.ADDR_W(ADDR_W)) chk_u (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .WHOLE_RADIO_RESET_I(WHOLE_RADIO_RESET_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .CHAN_TIME_O(CHAN_TIME_O), .MEM_RD_REQ_O(MEM_RD_REQ_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_RD_ACK_I(MEM_RD_ACK_I), .TXN_REQ_O(TXN_REQ_O), .TXN_ISO_O(TXN_ISO_O),
  .TXN_DONE_I(TXN_DONE_I), .TXN_OK_I(TXN_OK_I), .ASYNC_GO_O(ASYNC_GO_O));
